/* File: serial_host_and_parallel_out.v */
// serial host port with parallel output port and avalon control slave
// How it works
// - separate 16-bit in and out shifters, one shared 8-bit address register
// - writes carry one byte, reads return 16-bit words, frames are 16 bits
// - read data appears during the frame after the request
// - byte command fires only once its frame has finished
// - channel command latches own address from the four strap pins
// - slave only, never starts a transfer; host starts them all
// - serial output is open drain and doubles as ready
// - serial input sampled on every rising serial clock edge while selected
// - output shifter advances one bit on every rising serial clock edge while selected
// - frame: read flag, broadcast_n, op, channel, payload byte
// - write ops: 01 address, 10 data, 11 command, 00 reserved
// - read ops: 00 load hold, low word; 01 high word; 1x hold only
// - broadcast low reaches all on writes; reads and other writes reach only matching channel
// - low read load waits for sequence equal sync unless free running
// - serial output held low while a read load waits
// - parallel port streams selected register as two 16-bit halves
// - after reset the parallel port shows read address zero
// - upper parallel byte changes one clock after lower byte
// - word select level tells which half is on the pins
// - address loads and low word read requests change parallel output selection
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`include "serial_host_defs.vh"
`default_nettype none

module serial_host_and_parallel_out (
	// clock and reset
	input  wire        sys_clk_in,
	input  wire        rst_in,
	// serial link pins
	input  wire        serial_clk_in,
	input  wire        serial_select_n_in,
	input  wire        serial_in_in,
	output reg         serial_out_ready_out,
	output reg         serial_out_ready_oe_out,
	// address straps
	input  wire [3:0]  channel_strap_pins_in,
	// register datapath side
	output reg  [7:0]  read_addr_out,
	input  wire [31:0] read_data_in,
	output reg         reg_wr_strobe_out,
	output reg  [7:0]  reg_wr_data_out,
	output reg         cmd_strobe_out,
	output reg  [7:0]  cmd_code_out,
	// parallel port
	output reg  [15:0] par_data_out,
	output reg         word_half_select_out,
	output reg         strobe_pin_out,
	// avalon slave
	input  wire [3:0]  avs_address_in,
	input  wire        avs_read_in,
	input  wire        avs_write_in,
	input  wire [31:0] avs_writedata_in,
	input  wire [3:0]  avs_byteenable_in,
	output reg  [31:0] avs_readdata_out,
	output reg         avs_waitrequest_out
);

	// synchronisers
	reg        sclk_s1_reg;
	reg        sclk_s2_reg;
	reg        sclk_s3_reg;
	reg        sel_s1_reg;
	reg        sel_s2_reg;
	reg        sdi_s1_reg;
	reg        sdi_s2_reg;
	reg [3:0]  strap_s1_reg;
	reg [3:0]  strap_s2_reg;

	// serial engine
	reg [15:0] in_shift_reg;
	reg [15:0] out_shift_reg;
	reg [4:0]  bit_cnt_reg;
	reg        frame_done_reg;
	reg [15:0] frame_word_reg;
	reg [31:0] hold_reg;
	reg        load_wait_reg;
	reg        drive_reg;
	reg [3:0]  channel_reg;
	reg [7:0]  sync_reg;
	reg        strobe_en_reg;

	// sequence and parallel port
	reg [4:0]  seq_reg;
	reg [31:0] par_snap_reg;

	// control register
	reg        free_run_reg;

	wire sclk_rise;
	wire sel_active;
	wire frame_last;
	wire [15:0] in_shift_next;
	wire f_read;
	wire f_bcast_n;
	wire [1:0] f_op;
	wire [3:0] f_ch;
	wire [7:0] f_pay;
	wire w_hit;
	wire r_hit;
	wire load_now;
	wire av_req;
	wire av_do;

	// write target check: broadcast or own channel
	function ch_hit;
		input       bcast_n;
		input       use_bcast;
		input [3:0] ch;
		input [3:0] mine;
		begin
			ch_hit = (use_bcast & ~bcast_n) | (bcast_n & (ch == mine));
		end
	endfunction

	// edge found from stages two and three; stage one is never read here
	assign sclk_rise     = sclk_s2_reg & ~sclk_s3_reg;
	assign sel_active    = ~sel_s2_reg;
	assign frame_last    = sclk_rise & sel_active & (bit_cnt_reg == 5'h0f);
	assign in_shift_next = {in_shift_reg[14:0], sdi_s2_reg};

	assign f_read    = frame_word_reg[`FRM_READ_BIT];
	assign f_bcast_n = frame_word_reg[`FRM_BCAST_N_BIT];
	assign f_op      = frame_word_reg[`FRM_OP_HI:`FRM_OP_LO];
	assign f_ch      = frame_word_reg[`FRM_CH_HI:`FRM_CH_LO];
	assign f_pay     = frame_word_reg[7:0];

	// reads are never broadcast: single-channel systems send channel zero
	assign w_hit = ch_hit(f_bcast_n, 1'b1, f_ch, channel_reg);
	assign r_hit = ch_hit(1'b1, 1'b0, f_ch, channel_reg);

	assign load_now = load_wait_reg &
		(free_run_reg | (seq_reg == sync_reg[4:0]));

	assign av_req = avs_read_in | avs_write_in;
	assign av_do  = av_req & ~avs_waitrequest_out;

	// pin synchronisers, first stage feeds only the second
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_s1_reg  <= 1'b0;
			sclk_s2_reg  <= 1'b0;
			sclk_s3_reg  <= 1'b0;
			sel_s1_reg   <= 1'b1;
			sel_s2_reg   <= 1'b1;
			sdi_s1_reg   <= 1'b0;
			sdi_s2_reg   <= 1'b0;
			strap_s1_reg <= 4'h0;
			strap_s2_reg <= 4'h0;
		end else begin
			sclk_s1_reg  <= serial_clk_in;
			sclk_s2_reg  <= sclk_s1_reg;
			sclk_s3_reg  <= sclk_s2_reg;
			sel_s1_reg   <= serial_select_n_in;
			sel_s2_reg   <= sel_s1_reg;
			sdi_s1_reg   <= serial_in_in;
			sdi_s2_reg   <= sdi_s1_reg;
			strap_s1_reg <= channel_strap_pins_in;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	// bit counting and shifting, only while the host selects us
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			in_shift_reg   <= 16'h0000;
			bit_cnt_reg    <= 5'h00;
			frame_done_reg <= 1'b0;
			frame_word_reg <= 16'h0000;
		end else begin
			frame_done_reg <= 1'b0;
			if (!sel_active) begin
				// an aborted frame is dropped, never decoded
				bit_cnt_reg <= 5'h00;
			end else if (sclk_rise) begin
				in_shift_reg <= in_shift_next;
				if (frame_last) begin
					bit_cnt_reg    <= 5'h00;
					frame_done_reg <= 1'b1;
					frame_word_reg <= in_shift_next;
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
				end
			end
		end
	end

	// frame decode; frame_done pulses after the 16th edge
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			read_addr_out     <= `RST_READ_ADDR;
			reg_wr_strobe_out <= 1'b0;
			reg_wr_data_out   <= 8'h00;
			cmd_strobe_out    <= 1'b0;
			cmd_code_out      <= 8'h00;
			channel_reg       <= `RST_CHANNEL;
			sync_reg          <= 8'h00;
			strobe_en_reg     <= 1'b0;
			hold_reg          <= 32'h00000000;
			load_wait_reg     <= 1'b0;
			drive_reg         <= 1'b0;
			out_shift_reg     <= 16'hffff;
		end else begin
			reg_wr_strobe_out <= 1'b0;
			cmd_strobe_out    <= 1'b0;
			if (sclk_rise && sel_active) begin
				out_shift_reg <= {out_shift_reg[14:0], 1'b1};
			end
			if (load_now) begin
				// address settled a cycle ago, datapath word is valid
				hold_reg      <= read_data_in;
				out_shift_reg <= read_data_in[15:0];
				load_wait_reg <= 1'b0;
			end
			if (frame_done_reg) begin
				// every read frame ends the previous answer
				if (f_read) begin
					drive_reg     <= 1'b0;
					out_shift_reg <= 16'hffff;
				end
				if (!f_read && w_hit) begin
					if (f_op == `OP_LOAD_ADDRESS) begin
						read_addr_out <= f_pay;
					end else if (f_op == `OP_WRITE_DATA) begin
						reg_wr_strobe_out <= 1'b1;
						reg_wr_data_out   <= f_pay;
						if (read_addr_out == `WADDR_SYNC) begin
							sync_reg <= f_pay;
						end
						if (read_addr_out == `WADDR_TEST_CFG) begin
							strobe_en_reg <= f_pay[`TEST_STROBE_BIT];
						end
					end else if (f_op == `OP_WRITE_COMMAND) begin
						cmd_strobe_out <= 1'b1;
						cmd_code_out   <= f_pay;
					end
				end
				if (!f_read && !f_bcast_n && f_op == `OP_WRITE_COMMAND &&
					f_pay == `CMD_CHANNEL) begin
					channel_reg <= strap_s2_reg;
				end
				if (f_read && r_hit) begin
					drive_reg <= 1'b1;
					if (f_op == `OP_READ_LOW_LOAD) begin
						read_addr_out <= f_pay;
						load_wait_reg <= 1'b1;
					end else if (f_op == `OP_READ_HIGH) begin
						out_shift_reg <= hold_reg[31:16];
					end else begin
						out_shift_reg <= hold_reg[15:0];
					end
				end
			end
		end
	end

	// open drain output: only ever pulls low
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			serial_out_ready_out    <= 1'b0;
			serial_out_ready_oe_out <= 1'b0;
		end else begin
			serial_out_ready_out    <= 1'b0;
			serial_out_ready_oe_out <= load_wait_reg |
				(drive_reg & ~out_shift_reg[15]);
		end
	end

	// sequence counter wraps every 32 clocks
	// sync match uses only the low five bits of the sync byte
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			seq_reg <= 5'h00;
		end else begin
			seq_reg <= seq_reg + 5'h01;
		end
	end

	// parallel port, upper byte lags to spread switching current
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			par_snap_reg         <= 32'h00000000;
			par_data_out         <= 16'h0000;
			word_half_select_out <= 1'b0;
			strobe_pin_out       <= 1'b0;
		end else begin
			strobe_pin_out <= 1'b0;
			if (seq_reg == `SEQ_LOW_START) begin
				par_snap_reg         <= read_data_in;
				par_data_out[7:0]    <= read_data_in[7:0];
				word_half_select_out <= 1'b0;
			end else if (seq_reg == `SEQ_LOW_UPPER) begin
				par_data_out[15:8] <= par_snap_reg[15:8];
				strobe_pin_out     <= strobe_en_reg;
			end else if (seq_reg == `SEQ_HIGH_START) begin
				par_data_out[7:0]    <= par_snap_reg[23:16];
				word_half_select_out <= 1'b1;
			end else if (seq_reg == `SEQ_HIGH_UPPER) begin
				par_data_out[15:8] <= par_snap_reg[31:24];
				strobe_pin_out     <= strobe_en_reg;
			end
		end
	end

	// avalon slave, one wait state on every access
	// misaligned reads give zero; misaligned writes and writes to any word but control are dropped
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h00000000;
			free_run_reg        <= `RST_CTRL;
		end else begin
			avs_waitrequest_out <= 1'b1;
			if (av_req && avs_waitrequest_out) begin
				avs_waitrequest_out <= 1'b0;
				avs_readdata_out    <= 32'h00000000;
				if (avs_address_in[1:0] != 2'h0) begin
					avs_readdata_out <= 32'h00000000;
				end else if (avs_address_in[3:2] == `AV_CTRL) begin
					avs_readdata_out <= {31'h0, free_run_reg};
				end else if (avs_address_in[3:2] == `AV_STATUS) begin
					avs_readdata_out <= {26'h0, sel_active,
						load_wait_reg, channel_reg};
				end else if (avs_address_in[3:2] == `AV_ADDRESS) begin
					avs_readdata_out <= {24'h0, read_addr_out};
				end else begin
					avs_readdata_out <= {24'h0, sync_reg};
				end
			end
			if (av_do && avs_write_in && avs_byteenable_in[0] &&
				avs_address_in == 4'h0) begin
				free_run_reg <= avs_writedata_in[`CTRL_FREE_RUN_BIT];
			end
		end
	end

endmodule

`default_nettype wire

/* File: serial_host_defs.vh */
// constants for the serial host port and parallel output block
`ifndef SERIAL_HOST_DEFS_VH
`define SERIAL_HOST_DEFS_VH

// frame layout
`define FRAME_BITS        16
`define FRM_READ_BIT      15
`define FRM_BCAST_N_BIT   14
`define FRM_OP_HI         13
`define FRM_OP_LO         12
`define FRM_CH_HI         11
`define FRM_CH_LO         8

// operation codes, bits 13:12
`define OP_RESERVED       2'h0
`define OP_LOAD_ADDRESS   2'h1
`define OP_WRITE_DATA     2'h2
`define OP_WRITE_COMMAND  2'h3
`define OP_READ_LOW_LOAD  2'h0
`define OP_READ_HIGH      2'h1

// byte commands and serial write addresses
`define CMD_CHANNEL       8'h00
`define WADDR_SYNC        8'h03
`define WADDR_TEST_CFG    8'h04
`define TEST_STROBE_BIT   0

// parallel port sequence points
`define SEQ_LOW_START     5'h00
`define SEQ_LOW_UPPER     5'h01
`define SEQ_HIGH_START    5'h10
`define SEQ_HIGH_UPPER    5'h11

// avalon register word indices, compared with address bits 3:2
`define AV_CTRL           2'h0
`define AV_STATUS         2'h1
`define AV_ADDRESS        2'h2
`define AV_SYNC           2'h3
`define CTRL_FREE_RUN_BIT 0

// reset values
`define RST_READ_ADDR     8'h00
`define RST_CHANNEL       4'h0
`define RST_CTRL          1'h0

`endif

/* File: serial_host_and_parallel_out_end.v */
// spare design file, the block's logic lives in the main design file

/* File: shp_props.sv */
// assertion checker for the serial host and parallel port block
`default_nettype none
module shp_props (
	// clock and reset
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	// watched ports
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic        avs_waitrequest_out,
	input wire logic        serial_out_ready_out,
	input wire logic        reg_wr_strobe_out,
	input wire logic        cmd_strobe_out,
	input wire logic [7:0]  read_addr_out,
	input wire logic [15:0] par_data_out,
	input wire logic        word_half_select_out,
	input wire logic        strobe_pin_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	logic seen_reg;
	logic wsel_d_reg;
	// byte timing is only judged once a half toggle has been seen
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			seen_reg <= 1'b0;
			wsel_d_reg <= 1'b0;
		end else begin
			wsel_d_reg <= word_half_select_out;
			if (wsel_d_reg != word_half_select_out)
				seen_reg <= 1'b1;
		end
	end
	AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("avalon answer late");
	AST_WAIT_BACK: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	AST_OUT_ZERO: assert property (serial_out_ready_out == 1'b0)
		else $error("open drain value not low");
	AST_RST_ADDR: assert property ($past(rst_in) |-> read_addr_out == 8'h00)
		else $error("address not zero after reset");
	AST_WSEL_HI: assert property ($rose(word_half_select_out)
		|-> ##16 $fell(word_half_select_out)) else $error("high half length wrong");
	AST_WSEL_LO: assert property ($fell(word_half_select_out)
		|-> ##16 $rose(word_half_select_out)) else $error("low half length wrong");
	AST_STROBE_LAG: assert property (seen_reg && strobe_pin_out
		|-> $past(word_half_select_out) != $past(word_half_select_out, 2))
		else $error("strobe not one clock after half edge");
	AST_UPPER_LAG: assert property (seen_reg && $changed(par_data_out[15:8])
		|-> $past(word_half_select_out) != $past(word_half_select_out, 2))
		else $error("upper byte not one clock late");
	AST_LOWER_AT_HALF: assert property (seen_reg && $changed(par_data_out[7:0])
		|-> $changed(word_half_select_out)) else $error("lower byte off half edge");
	AST_WR_PULSE: assert property (reg_wr_strobe_out |=> !reg_wr_strobe_out)
		else $error("write strobe too long");
	AST_CMD_PULSE: assert property (cmd_strobe_out |=> !cmd_strobe_out)
		else $error("command strobe too long");
	cover property (cmd_strobe_out);
	cover property (reg_wr_strobe_out);
	cover property ($rose(word_half_select_out));
endmodule
bind serial_host_and_parallel_out shp_props u_props (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
	.serial_out_ready_out(serial_out_ready_out), .reg_wr_strobe_out(reg_wr_strobe_out),
	.cmd_strobe_out(cmd_strobe_out), .read_addr_out(read_addr_out),
	.par_data_out(par_data_out), .word_half_select_out(word_half_select_out),
	.strobe_pin_out(strobe_pin_out));
`default_nettype wire

/* File: host_model.sv */
// host model that drives serial frames and reads the open drain line
`default_nettype none
module host_model (
	// link pins
	output logic      sclk_out,
	output logic      sel_n_out,
	output logic      sdi_out,
	input  wire logic pin_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		sdi_out = 1'b0;
	end
	// only the host starts transfers
	task automatic frame(input logic [15:0] w, output logic [15:0] r);
		integer i;
		#7 sel_n_out = 1'b0;
		for (i = 15; i >= 0; i--) begin // msb first
			sdi_out = w[i];
			#100 sclk_out = 1'b1; // 16 clocks under select
			r[i] = pin_in;
			#100 sclk_out = 1'b0;
		end
		#100 sel_n_out = 1'b1;
		sdi_out = ~sdi_out; // idle data must not look like the last bit
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the serial host and parallel port block
`include "serial_host_defs.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_in, rst_in, sclk, sel_n, serial_in, rdy, rdy_oe, wr_stb, cmd_stb, wsel, av_rd, av_wr;
	logic av_wait, saw, strb;
	logic [3:0] straps, av_addr, av_be, ch;
	logic [7:0] raddr, wr_data, cmd_code, wr_d, wr_a, last_cmd, a, d, c;
	logic [15:0] par, rx;
	logic [31:0] av_wd, av_rdata, q;
	integer n_errors = 0, check_count = 0, k;
	wire logic pin = rdy_oe ? rdy : 1'b1; // pull-up on the open drain line
	function automatic logic [31:0] reg_val(input logic [7:0] x);
		return {8'h5a ^ x, ~x, 8'h80 | x, x};
	endfunction
	serial_host_and_parallel_out uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.serial_clk_in(sclk), .serial_select_n_in(sel_n), .serial_in_in(serial_in),
		.serial_out_ready_out(rdy), .serial_out_ready_oe_out(rdy_oe),
		.channel_strap_pins_in(straps), .read_addr_out(raddr), .read_data_in(reg_val(raddr)),
		.reg_wr_strobe_out(wr_stb), .reg_wr_data_out(wr_data), .cmd_strobe_out(cmd_stb),
		.cmd_code_out(cmd_code), .par_data_out(par), .word_half_select_out(wsel),
		.strobe_pin_out(strb), .avs_address_in(av_addr), .avs_read_in(av_rd),
		.avs_write_in(av_wr), .avs_writedata_in(av_wd), .avs_byteenable_in(av_be),
		.avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait));
	host_model host (.sclk_out(sclk), .sel_n_out(sel_n), .sdi_out(serial_in), .pin_in(pin));
	always @(posedge sys_clk_in) begin
		if (wr_stb === 1'b1) begin
			wr_d <= wr_data;
			wr_a <= raddr;
		end
		if (cmd_stb === 1'b1)
			last_cmd <= cmd_code;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic av(input logic w, input logic [3:0] ad, input logic [31:0] wd);
		@(posedge sys_clk_in);
		av_rd <= !w;
		av_wr <= w;
		av_addr <= ad;
		av_wd <= wd;
		@(posedge sys_clk_in);
		while (av_wait !== 1'b0)
			@(posedge sys_clk_in);
		q = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask
	task automatic sf(input logic [15:0] w);
		host.frame(w, rx);
		repeat (6) @(posedge sys_clk_in);
	endtask
	task automatic wait_ready;
		saw = 1'b0;
		repeat (100) begin
			@(posedge sys_clk_in);
			if (pin === 1'b0)
				saw = 1'b1;
		end
	endtask
	task automatic par_chk(input logic [7:0] x);
		repeat (2) @(posedge wsel);
		repeat (3) @(posedge sys_clk_in); // upper byte unsettled at the half edge
		chk("par high", reg_val(x) >> 16, par);
		@(negedge wsel);
		repeat (3) @(posedge sys_clk_in);
		chk("par low", reg_val(x) & 32'hffff, par);
	endtask
	task automatic strobe_count(input logic [31:0] exp);
		integer n;
		n = 0;
		repeat (32) begin
			@(posedge sys_clk_in);
			if (strb === 1'b1)
				n++;
		end
		chk("strobe pulses", exp, n);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		#400000;
		n_errors++;
		complete_run;
	end
	initial begin
		rst_in = 1'b1;
		{av_rd, av_wr, av_addr, av_wd, straps} = '0;
		av_be = 4'hf;
		void'($urandom(20));
		repeat (4) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		chk("read address", 8'h00, raddr);
		av(1'b0, {`AV_CTRL, 2'b00}, 0);
		chk("ctrl", 0, q);
		par_chk(8'h00);
		$display("test reset done");
		ch = 4'($urandom);
		straps <= ch;
		sf(16'h3000);
		av(1'b0, {`AV_STATUS, 2'b00}, 0);
		chk("channel", ch, q & 32'hf);
		for (k = 0; k < 4; k++) begin
			a = 8'($urandom);
			d = 8'($urandom);
			c = 8'($urandom) | 8'h01;
			sf({8'h10, a});
			chk("load address", a, raddr);
			sf({4'h6, ch, d});
			chk("write byte", {a, d}, {wr_a, wr_d});
			sf({4'h7, ch, c});
			chk("command", c, last_cmd);
			sf({4'h5, ch ^ 4'h1, ~a});
			sf({4'h0, ch, ~a});
			chk("ignored frames", a, raddr);
		end
		$display("test writes done");
		strobe_count(0);
		sf(16'h1004);
		sf(16'h2001);
		strobe_count(2);
		$display("test strobe done");
		av(1'b1, {`AV_CTRL, 2'b00}, 32'h1);
		for (k = 0; k < 2; k++) begin
			a = 8'($urandom);
			sf({4'hc, ch, a});
			wait_ready;
			sf({4'hd, ch, 8'h00});
			chk("low word", reg_val(a) & 32'hffff, rx);
			sf({4'he, ch, 8'h00});
			chk("high word", reg_val(a) >> 16, rx);
			sf({4'hf, ch, 8'h00});
			chk("hold word", reg_val(a) & 32'hffff, rx);
			av(1'b0, {`AV_ADDRESS, 2'b00}, 0);
			chk("address reg", a, q);
			par_chk(a);
		end
		$display("test free running reads done");
		av(1'b1, {`AV_CTRL, 2'b00}, 0);
		sf(16'h1003);
		sf(16'h2002);
		av(1'b0, {`AV_SYNC, 2'b00}, 0);
		chk("sync", 8'h02, q);
		a = 8'($urandom);
		@(posedge wsel);
		sf({4'hc, ch, a});
		wait_ready;
		chk("not ready seen", 1'b1, saw);
		sf({4'hd, ch, 8'h00});
		chk("synced low word", reg_val(a) & 32'hffff, rx);
		$display("test synchronous read done");
		av(1'b0, 4'h5, 0);
		chk("misaligned read", 0, q);
		av(1'b1, {`AV_ADDRESS, 2'b00}, 32'h0);
		av(1'b0, {`AV_ADDRESS, 2'b00}, 0);
		chk("read only address", a, q);
		$display("test avalon refusals done");
		complete_run;
	end
endmodule
`default_nettype wire
